// file: hdl/gpio_pkg.sv
package gpio_pkg;
  // Register group base addresses (addr[5:2] selects the group, addr[1:0] the alias)
  localparam logic [5:0] REG_DIR = 6'h00;
  localparam logic [5:0] REG_PIN = 6'h04;
  localparam logic [5:0] REG_LAT = 6'h08;
  localparam logic [5:0] REG_ODC = 6'h0C;
  localparam logic [5:0] REG_ANS = 6'h10;
  localparam logic [5:0] REG_CNEN = 6'h14;
  localparam logic [5:0] REG_CNST = 6'h18;
  localparam logic [5:0] REG_PU = 6'h1C;
  localparam logic [5:0] REG_PD = 6'h20;
  localparam logic [5:0] REG_CNCON = 6'h24;
  // Alias sub-offsets inside each register group
  localparam logic [1:0] ALIAS_BASE = 2'h0;
  localparam logic [1:0] ALIAS_CLR = 2'h1;
  localparam logic [1:0] ALIAS_SET = 2'h2;
  localparam logic [1:0] ALIAS_INV = 2'h3;
  // Control register fields
  localparam int CN_ON_BIT = 15;
  localparam int CN_IDLE_BIT = 13;
  // Reset values
  localparam logic [15:0] DIR_RST = 16'hFFFF;
  localparam logic [15:0] ANS_RST = 16'hFFFF;
  localparam logic [15:0] ZERO_RST = 16'h0000;
  localparam logic [15:0] CNCON_MASK = 16'hA000;
  localparam int SYNC_STAGES = 2;
endpackage

// file: hdl/pin_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for a vector of asynchronous pins
module pin_sync #(
  parameter int WIDTH = 16
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // First stage feeds only the second stage
  always_comb begin
    st_nxt.meta = async_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;
endmodule

// file: hdl/gpio_port.sv
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
// Functional notes
// RL1: Direction bit one means input; reset inputs
// RL2: Latch reads return latch, writes update latch
// RL3: Pin reads sample pins; writes hit latch
// RL4: Open-drain bit forces open-drain, remapped too
// RL5: I2C pins always open-drain
// RL6: Software sets analog plus direction correctly
// RL7: Analog select resets to all ones
// RL8: Direction gates only the digital driver
// RL9: Analog pins read zero on pin reads
// RL10: Software waits one cycle before read-back
// RL11: Enabled pin change raises interrupt, even asleep
// RL12: Per-pin enable selects change interrupt source
// RL13: Status shows change since last pin read
// RL14: Independent pull-up and pull-down enables
// RL15: Software disables pulls on outputs, 5V pins
// RL16: Control bit 15 enables change notification
// RL17: Control bit 13 halts detection in idle
// RL18: Clear, set, invert aliases modify ones only
// RL19: Pins synchronised before reading or detection
// RL20: Interrupt is OR of enabled status, gated
module gpio_port
  import gpio_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter logic [15:0] I2C_PINS = 16'h0000
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [5:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  input wire logic [WIDTH-1:0] remap_pin_select,
  input wire logic [WIDTH-1:0] remap_out,
  output logic [WIDTH-1:0] pull_up_on,
  output logic [WIDTH-1:0] pull_down_on,
  output logic [WIDTH-1:0] analog_on,
  output logic [WIDTH-1:0] analog_drive,
  input wire logic cpu_idle,
  output logic input_change_notify
);
  typedef struct packed {
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] lat;
    logic [WIDTH-1:0] odc;
    logic [WIDTH-1:0] ans;
    logic [WIDTH-1:0] cnen;
    logic [WIDTH-1:0] cnst;
    logic [WIDTH-1:0] pu;
    logic [WIDTH-1:0] pd;
    logic [WIDTH-1:0] prev;
    logic cn_on;
    logic cn_idle;
    logic [15:0] rdata;
    logic [WIDTH-1:0] pin_out;
    logic [WIDTH-1:0] pin_oe;
    logic [WIDTH-1:0] analog_drive;
    logic irq;
  } port_state_t;

  port_state_t st_r;
  port_state_t st_nxt;
  logic [WIDTH-1:0] pin_s;
  logic [WIDTH-1:0] wmask;
  logic [WIDTH-1:0] digital_level;
  logic [WIDTH-1:0] open_drain;
  logic [WIDTH-1:0] change;
  logic detect_on;
  logic [3:0] group;
  logic [1:0] alias_op;
  logic hit_pin;

  // Apply base write or clear/set/invert alias to one register
  function automatic logic [WIDTH-1:0] apply_write(
    input logic [WIDTH-1:0] cur,
    input logic [WIDTH-1:0] data,
    input logic [1:0] op
  );
    logic [WIDTH-1:0] res;
    res = cur;
    case (op)
      ALIAS_BASE: res = data;
      ALIAS_CLR: res = cur & ~data;
      ALIAS_SET: res = cur | data;
      ALIAS_INV: res = cur ^ data;
      default: res = cur;
    endcase
    return res;
  endfunction

  // Same alias rules for a single control bit
  function automatic logic apply_bit(
    input logic cur,
    input logic data,
    input logic [1:0] op
  );
    logic res;
    res = cur;
    case (op)
      ALIAS_BASE: res = data;
      ALIAS_CLR: res = cur & ~data;
      ALIAS_SET: res = cur | data;
      ALIAS_INV: res = cur ^ data;
      default: res = cur;
    endcase
    return res;
  endfunction

  // Pins cross into mclk through two flops
  pin_sync #(
    .WIDTH(WIDTH)
  ) u_sync (
    .mclk(mclk),
    .reset(reset),
    .async_in(pin_in),
    .sync_out(pin_s) // RL19
  );

  assign wmask = wdata[WIDTH-1:0];
  assign group = addr[5:2];
  assign alias_op = addr[1:0];
  assign hit_pin = rd && (addr == REG_PIN);

  // Remapped peripheral wins over latch on the digital path
  assign digital_level = (remap_pin_select & remap_out) | (~remap_pin_select & st_r.lat);
  assign open_drain = st_r.odc | I2C_PINS; // RL4 RL5

  // Idle halt only matters while the core idles; detection needs no core clock
  assign detect_on = st_r.cn_on && !(st_r.cn_idle && cpu_idle); // RL16 RL17
  assign change = (pin_s ^ st_r.prev) & ~st_r.ans;

  always_comb begin
    st_nxt = st_r;
    // Register writes, aliases touch only the one bits
    if (wr) begin
      case (group)
        REG_DIR[5:2]: st_nxt.dir = apply_write(st_r.dir, wmask, alias_op); // RL18
        REG_PIN[5:2]: st_nxt.lat = apply_write(st_r.lat, wmask, alias_op); // RL3
        REG_LAT[5:2]: st_nxt.lat = apply_write(st_r.lat, wmask, alias_op); // RL2
        REG_ODC[5:2]: st_nxt.odc = apply_write(st_r.odc, wmask, alias_op);
        REG_ANS[5:2]: st_nxt.ans = apply_write(st_r.ans, wmask, alias_op);
        REG_CNEN[5:2]: st_nxt.cnen = apply_write(st_r.cnen, wmask, alias_op); // RL12
        REG_CNST[5:2]: st_nxt.cnst = apply_write(st_r.cnst, wmask, alias_op);
        REG_PU[5:2]: st_nxt.pu = apply_write(st_r.pu, wmask, alias_op); // RL14
        REG_PD[5:2]: st_nxt.pd = apply_write(st_r.pd, wmask, alias_op); // RL14
        REG_CNCON[5:2]: begin
          st_nxt.cn_on = apply_bit(st_r.cn_on, wdata[CN_ON_BIT], alias_op); // RL16
          st_nxt.cn_idle = apply_bit(st_r.cn_idle, wdata[CN_IDLE_BIT], alias_op); // RL17
        end
        default: st_nxt.dir = st_r.dir;
      endcase
    end
    // Pin read clears status; a change in the same cycle wins
    if (hit_pin) begin
      st_nxt.cnst = '0; // RL13
      st_nxt.prev = pin_s;
    end
    if (detect_on) begin
      st_nxt.cnst = st_nxt.cnst | change; // RL13
      if (!hit_pin) begin
        st_nxt.prev = (st_r.prev & ~change) | (pin_s & change);
      end
    end else if (!hit_pin) begin
      st_nxt.prev = pin_s;
    end
    // Read data, valid the cycle after the strobe
    st_nxt.rdata = 16'h0000;
    if (rd && alias_op == ALIAS_BASE) begin
      case (group)
        REG_DIR[5:2]: st_nxt.rdata[WIDTH-1:0] = st_r.dir;
        REG_PIN[5:2]: st_nxt.rdata[WIDTH-1:0] = pin_s & ~st_r.ans; // RL3 RL9
        REG_LAT[5:2]: st_nxt.rdata[WIDTH-1:0] = st_r.lat; // RL2
        REG_ODC[5:2]: st_nxt.rdata[WIDTH-1:0] = st_r.odc;
        REG_ANS[5:2]: st_nxt.rdata[WIDTH-1:0] = st_r.ans;
        REG_CNEN[5:2]: st_nxt.rdata[WIDTH-1:0] = st_r.cnen;
        REG_CNST[5:2]: st_nxt.rdata[WIDTH-1:0] = st_r.cnst;
        REG_PU[5:2]: st_nxt.rdata[WIDTH-1:0] = st_r.pu;
        REG_PD[5:2]: st_nxt.rdata[WIDTH-1:0] = st_r.pd;
        REG_CNCON[5:2]: begin
          st_nxt.rdata[CN_ON_BIT] = st_r.cn_on;
          st_nxt.rdata[CN_IDLE_BIT] = st_r.cn_idle;
        end
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
    // Pad drive: open-drain pins only pull low
    st_nxt.pin_out = digital_level & ~open_drain;
    st_nxt.pin_oe = ~st_r.dir & (~open_drain | ~digital_level); // RL1 RL4 RL8
    st_nxt.analog_drive = digital_level; // RL8
    st_nxt.irq = st_r.cn_on && |(st_r.cnst & st_r.cnen); // RL11 RL20
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= '0;
      st_r.dir <= DIR_RST[WIDTH-1:0]; // RL1
      st_r.ans <= ANS_RST[WIDTH-1:0]; // RL7
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign pin_out = st_r.pin_out;
  assign pin_oe = st_r.pin_oe;
  assign analog_drive = st_r.analog_drive;
  assign input_change_notify = st_r.irq;
  assign pull_up_on = st_r.pu;
  assign pull_down_on = st_r.pd;
  assign analog_on = st_r.ans;

  // Reset state: every pin an input, every analog-capable pin analog
  reset_inputs_a: assert property (@(posedge mclk) // RL1
    $past(reset) && !reset |-> pin_oe == '0)
    else $error("pins not inputs after reset");
  analog_reset_a: assert property (@(posedge mclk) // RL7
    $past(reset) |-> analog_on == ANS_RST[WIDTH-1:0])
    else $error("analog select reset wrong");

  // Base writes land one cycle after the strobe
  latch_write_a: assert property (@(posedge mclk) disable iff (reset) // RL2
    wr && addr == REG_LAT |=> st_r.lat == $past(wmask))
    else $error("latch write lost");
  pin_write_a: assert property (@(posedge mclk) disable iff (reset) // RL3
    wr && addr == REG_PIN |=> st_r.lat == $past(wmask))
    else $error("pin write missed latch");
  dir_write_a: assert property (@(posedge mclk) disable iff (reset) // RL1
    wr && addr == REG_DIR |=> st_r.dir == $past(wmask))
    else $error("direction write lost");
  odc_write_a: assert property (@(posedge mclk) disable iff (reset) // RL4
    wr && addr == REG_ODC |=> st_r.odc == $past(wmask))
    else $error("open drain write lost");
  ans_write_a: assert property (@(posedge mclk) disable iff (reset) // RL7
    wr && addr == REG_ANS |=> analog_on == $past(wmask))
    else $error("analog select write lost");
  cnen_write_a: assert property (@(posedge mclk) disable iff (reset) // RL12
    wr && addr == REG_CNEN |=> st_r.cnen == $past(wmask))
    else $error("change enable write lost");
  pull_up_write_a: assert property (@(posedge mclk) disable iff (reset) // RL14
    wr && addr == REG_PU |=> pull_up_on == $past(wmask))
    else $error("pull up write lost");
  pull_dn_write_a: assert property (@(posedge mclk) disable iff (reset) // RL14
    wr && addr == REG_PD |=> pull_down_on == $past(wmask))
    else $error("pull down write lost");
  ctl_on_write_a: assert property (@(posedge mclk) disable iff (reset) // RL16
    wr && addr == REG_CNCON |=> st_r.cn_on == $past(wdata[CN_ON_BIT]))
    else $error("control enable write lost");
  ctl_idle_write_a: assert property (@(posedge mclk) disable iff (reset) // RL17
    wr && addr == REG_CNCON |=> st_r.cn_idle == $past(wdata[CN_IDLE_BIT]))
    else $error("control idle write lost");

  // Aliases touch only the bits written as one
  set_alias_a: assert property (@(posedge mclk) disable iff (reset) // RL18
    wr && addr == (REG_DIR | 6'(ALIAS_SET)) |=> st_r.dir == ($past(st_r.dir) | $past(wmask)))
    else $error("set alias wrong");
  clr_alias_a: assert property (@(posedge mclk) disable iff (reset) // RL18
    wr && addr == (REG_ODC | 6'(ALIAS_CLR)) |=> st_r.odc == ($past(st_r.odc) & ~$past(wmask)))
    else $error("clear alias wrong");
  inv_alias_a: assert property (@(posedge mclk) disable iff (reset) // RL18
    wr && addr == (REG_CNEN | 6'(ALIAS_INV)) |=> st_r.cnen == ($past(st_r.cnen) ^ $past(wmask)))
    else $error("invert alias wrong");
  alias_read_a: assert property (@(posedge mclk) disable iff (reset) // RL18
    rd && alias_op != ALIAS_BASE |=> rdata == 16'h0000)
    else $error("alias read not zero");

  // Read data stand only in the cycle after the strobe
  rdata_idle_a: assert property (@(posedge mclk) disable iff (reset) // RL2
    !$past(rd) |-> rdata == 16'h0000)
    else $error("read data without strobe");
  latch_read_a: assert property (@(posedge mclk) disable iff (reset) // RL2
    rd && addr == REG_LAT |=> rdata[WIDTH-1:0] == $past(st_r.lat))
    else $error("latch read wrong");
  dir_read_a: assert property (@(posedge mclk) disable iff (reset) // RL1
    rd && addr == REG_DIR |=> rdata[WIDTH-1:0] == $past(st_r.dir))
    else $error("direction read wrong");
  pin_read_a: assert property (@(posedge mclk) disable iff (reset) // RL3
    rd && addr == REG_PIN |=> rdata[WIDTH-1:0] == ($past(pin_s) & ~$past(st_r.ans)))
    else $error("pin read wrong");
  analog_zero_a: assert property (@(posedge mclk) disable iff (reset) // RL9
    rd && addr == REG_PIN |=> (rdata[WIDTH-1:0] & $past(st_r.ans)) == '0)
    else $error("analog pin read nonzero");
  status_read_a: assert property (@(posedge mclk) disable iff (reset) // RL13
    rd && addr == REG_CNST |=> rdata[WIDTH-1:0] == $past(st_r.cnst))
    else $error("status read wrong");
  ctl_read_a: assert property (@(posedge mclk) disable iff (reset) // RL16
    rd && addr == REG_CNCON |=> rdata[CN_ON_BIT] == $past(st_r.cn_on))
    else $error("control read wrong");

  // Pad drive, one cycle behind the registers
  od_drive_a: assert property (@(posedge mclk) disable iff (reset) // RL4 RL5
    ((pin_out & $past(open_drain)) == '0))
    else $error("open drain pin drove high");
  push_pull_a: assert property (@(posedge mclk) disable iff (reset) // RL4
    ((pin_out ^ $past(digital_level)) & ~$past(open_drain)) == '0)
    else $error("push pull level wrong");
  i2c_od_a: assert property (@(posedge mclk) disable iff (reset) // RL5
    (pin_out & I2C_PINS[WIDTH-1:0]) == '0)
    else $error("i2c pin drove high");
  dir_gate_a: assert property (@(posedge mclk) disable iff (reset) // RL1 RL8
    (pin_oe & $past(st_r.dir)) == '0)
    else $error("input pin driven");
  oe_follow_a: assert property (@(posedge mclk) disable iff (reset) // RL8
    ((pin_oe ^ ~$past(st_r.dir)) & ~$past(open_drain)) == '0)
    else $error("output buffer not per direction");
  analog_out_a: assert property (@(posedge mclk) disable iff (reset) // RL8
    analog_drive == $past(digital_level))
    else $error("analog side lost output level");
  remap_path_a: assert property (@(posedge mclk) disable iff (reset) // RL4
    ((analog_drive ^ $past(remap_out)) & $past(remap_pin_select)) == '0)
    else $error("remapped output lost");

  // Two flops between pad and any reader
  sync_delay_a: assert property (@(posedge mclk) disable iff (reset) // RL19
    !$past(reset) && !$past(reset, 2) |-> pin_s == $past(pin_in, 2))
    else $error("pin sync delay wrong");

  // Change status and interrupt request
  status_set_a: assert property (@(posedge mclk) disable iff (reset) // RL13
    detect_on && (|change) |=> (st_r.cnst & $past(change)) == $past(change))
    else $error("change not recorded");
  status_clear_a: assert property (@(posedge mclk) disable iff (reset) // RL13
    hit_pin && !detect_on |=> st_r.cnst == '0)
    else $error("status not cleared by pin read");
  cn_off_a: assert property (@(posedge mclk) disable iff (reset) // RL16
    !detect_on && !hit_pin && !wr |=> st_r.cnst == $past(st_r.cnst))
    else $error("status moved while detection off");
  idle_halt_a: assert property (@(posedge mclk) disable iff (reset) // RL17
    st_r.cn_idle && cpu_idle && !hit_pin && !wr |=> st_r.cnst == $past(st_r.cnst))
    else $error("status moved in idle halt");
  irq_gate_a: assert property (@(posedge mclk) disable iff (reset) // RL16 RL20
    !$past(st_r.cn_on) |-> !input_change_notify)
    else $error("interrupt while disabled");
  irq_cause_a: assert property (@(posedge mclk) disable iff (reset) // RL11 RL12
    st_r.cn_on && |(st_r.cnst & st_r.cnen) |=> input_change_notify)
    else $error("interrupt not raised");
  irq_mask_a: assert property (@(posedge mclk) disable iff (reset) // RL12 RL20
    !(|($past(st_r.cnst) & $past(st_r.cnen))) |-> !input_change_notify)
    else $error("interrupt without enabled status");
endmodule

// file: sim/pin_world.sv
`timescale 1ns/10ps
// Pads beyond the port: outside drivers, weak pulls, remapped peripheral
module pin_world (
  input wire logic mclk,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] pull_up_on,
  input wire logic [15:0] pull_down_on,
  input wire logic [15:0] ext_en,
  input wire logic [15:0] ext_val,
  input wire logic [15:0] remap_req,
  input wire logic [15:0] remap_dat,
  output logic [15:0] pin_in,
  output logic [15:0] remap_pin_select,
  output logic [15:0] remap_out
);
  logic float_r = 1'b0;
  // Peripheral side of the remap path
  assign remap_pin_select = remap_req;
  assign remap_out = remap_dat;
  // Undriven pads wander each cycle, so a stale level is never trusted
  always_ff @(posedge mclk) begin
    float_r <= ~float_r;
  end
  // Port drive wins, then the outside driver, then the weak pulls
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pull_up_on[i]) pin_in[i] = 1'b1;
      else if (pull_down_on[i]) pin_in[i] = 1'b0;
      else pin_in[i] = float_r;
    end
  end
endmodule

// file: sim/gpio_port_test.sv
`timescale 1ns/10ps
module gpio_port_test
  import gpio_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cpu_idle = 1'b0;
  logic [15:0] ext_en = 16'hFFFF;
  logic [15:0] ext_val = 16'hFFFF;
  logic [15:0] remap_req = 16'h0000;
  logic [15:0] remap_dat = 16'h0000;
  logic [15:0] rdata, pin_in, pin_out, pin_oe, pull_up_on, pull_down_on;
  logic [15:0] analog_on, analog_drive, remap_pin_select, remap_out;
  logic input_change_notify;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;

  gpio_port #(.WIDTH(16), .I2C_PINS(16'h0003)) dut (.mclk(mclk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .remap_pin_select(remap_pin_select), .remap_out(remap_out),
    .pull_up_on(pull_up_on), .pull_down_on(pull_down_on), .analog_on(analog_on),
    .analog_drive(analog_drive), .cpu_idle(cpu_idle),
    .input_change_notify(input_change_notify));
  pin_world pads (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_on(pull_up_on),
    .pull_down_on(pull_down_on), .ext_en(ext_en), .ext_val(ext_val), .remap_req(remap_req),
    .remap_dat(remap_dat), .pin_in(pin_in), .remap_pin_select(remap_pin_select),
    .remap_out(remap_out));

  initial begin
    forever #5 mclk = ~mclk;
  end
  // Hang guard, far above the 120 or so cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // One-cycle write strobe beside address and data
  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic set_ext(input logic [15:0] v);
    @(posedge mclk);
    ext_val <= v;
  endtask

  task automatic t_reset();
    rd_chk(REG_DIR, DIR_RST);
    rd_chk(REG_ANS, ANS_RST);
    rd_chk(REG_CNCON, 16'h0000);
    chk(pin_oe, 16'h0000);
    chk(analog_on, 16'hFFFF);
    rd_chk(REG_PIN, 16'h0000);
  endtask
  task automatic t_latch();
    wr_reg(REG_LAT, 16'hA5A5);
    wr_reg({REG_LAT[5:2], ALIAS_SET}, 16'h0F00);
    wr_reg({REG_LAT[5:2], ALIAS_CLR}, 16'h0005);
    wr_reg({REG_LAT[5:2], ALIAS_INV}, 16'h00FF);
    rd_chk(REG_LAT, 16'hAF5F);
    rd_chk({REG_LAT[5:2], ALIAS_INV}, 16'h0000);
    wr_reg(REG_PIN, 16'h1234);
    wr_reg(6'h3C, 16'hFFFF);
    rd_chk(6'h3C, 16'h0000);
    rd_chk(REG_LAT, 16'h1234);
    rd_chk(REG_PIN, 16'h0000);
  endtask
  // Low byte as outputs: pin 4 open-drain, pins 0-1 I2C, pin 2 remapped low
  task automatic t_drive();
    @(posedge mclk);
    ext_en <= 16'hFF00;
    remap_req <= 16'h0004;
    wr_reg(REG_ANS, 16'h0000);
    wr_reg({REG_DIR[5:2], ALIAS_CLR}, 16'h00FF);
    wr_reg(REG_ODC, 16'h0010);
    wr_reg({REG_LAT[5:2], ALIAS_SET}, 16'h0001);
    wr_reg(REG_PU, 16'h00FF);
    wr_reg(REG_PD, 16'hF000);
    idle(4);
    chk(pin_oe, 16'h00EE);
    chk(pin_out & 16'h00FF, 16'h0020);
    chk(pull_up_on, 16'h00FF);
    chk(pull_down_on, 16'hF000);
    rd_chk(REG_PIN, 16'hFF31);
    wr_reg(REG_ANS, 16'h00FF);
    idle(2);
    chk(analog_drive & 16'h00E0, 16'h0020);
    wr_reg(REG_ANS, 16'h0000);
  endtask
  task automatic t_change();
    wr_reg(REG_CNCON, 16'h8000);
    wr_reg(REG_CNEN, 16'h0100);
    idle(4);
    rd_chk(REG_PIN, 16'hFF31);
    set_ext(16'hFDFF);
    idle(6);
    chk({15'h0000, input_change_notify}, 16'h0000);
    rd_chk(REG_CNST, 16'h0200);
    rd_chk(REG_PIN, 16'hFD31);
    set_ext(16'hFCFF);
    idle(1);
    chk({15'h0000, input_change_notify}, 16'h0000);
    idle(5);
    chk({15'h0000, input_change_notify}, 16'h0001);
    rd_chk(REG_CNST, 16'h0100);
    rd_chk(REG_PIN, 16'hFC31);
    idle(2);
    chk({15'h0000, input_change_notify}, 16'h0000);
    wr_reg(REG_CNCON, 16'hA000);
    cpu_idle <= 1'b1;
    set_ext(16'hFDFF);
    idle(6);
    chk({15'h0000, input_change_notify}, 16'h0000);
    @(posedge mclk);
    cpu_idle <= 1'b0;
    wr_reg(REG_CNCON, 16'h0000);
    set_ext(16'hFCFF);
    idle(6);
    chk({15'h0000, input_change_notify}, 16'h0000);
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_latch();
    t_drive();
    t_change();
    wrap_up();
  end
endmodule
